// ==== design/lqeo_encoder_out.sv ====
`timescale 1ns/100ps
// Overview of operation
// - A and B are square waves ninety electrical degrees apart.
// - Index pulse every fifty millimetres of travel.
// - Fault output asserts on power, light source or contamination failure.
// - Resolution 0.5 to 10 um from 40 um pitch with 4x decode.
module lqeo_encoder_out
#(
    parameter int unsigned RES_NM = lqeo_pkg::RES_DEFAULT_NM
)
(
    input  wire logic               core_clk_i,
    input  wire logic               reset_i,
    input  wire logic               move_step_i,
    input  wire logic               move_dir_i,
    input  wire logic               power_ok_i,
    input  wire logic               light_ok_i,
    input  wire logic               scale_clean_i,
    output logic                    chan_a_o,
    output logic                    chan_b_o,
    output logic                    index_o,
    output logic                    fault_o,
    output logic                    fault_n_o,
    output logic [lqeo_pkg::POS_W-1:0] position_o
);
    // One step is one count of 4x decoding, so one resolution unit of travel.
    localparam int unsigned STEPS_PER_INDEX = lqeo_pkg::INDEX_PITCH_NM / RES_NM;
    localparam int unsigned IDX_W           = (STEPS_PER_INDEX > 1) ? $clog2(STEPS_PER_INDEX) : 1;
    localparam int unsigned POS_W           = lqeo_pkg::POS_W;
    localparam logic [IDX_W-1:0] IDX_LAST   = IDX_W'(STEPS_PER_INDEX - 1);
    localparam logic [IDX_W-1:0] IDX_FIRST  = IDX_W'(0);
    localparam logic [IDX_W-1:0] IDX_ONE    = IDX_W'(1);
    localparam logic [POS_W-1:0] POS_ONE    = POS_W'(1);

    lqeo_step_if stp ();

    lqeo_pkg::lqeo_state_t       state_ff;
    logic [IDX_W-1:0]            idx_cnt_ff;
    logic [POS_W-1:0]            pos_ff;
    logic                        chan_a_ff;
    logic                        chan_b_ff;
    logic                        index_ff;
    logic                        fault_ff;
    logic                        healthy;
    logic                        in_run;
    logic                        step_ok;
    logic                        step_fwd;
    logic                        nxt_at_index;

    // Channel A is the upper bit of the quadrature phase.
    function automatic logic chan_a_of(input logic [1:0] phase);
        return phase[1];
    endfunction

    // Channel B is the Gray partner of A, so only one pin moves per phase step.
    function automatic logic chan_b_of(input logic [1:0] phase);
        return phase[1] ^ phase[0];
    endfunction

    // Direction decode shared by the index counter and the position counter.
    function automatic logic is_fwd(input logic dir);
        return dir == lqeo_pkg::DIR_FWD;
    endfunction

    // Next index count for one step, wrapping at both ends of the pitch.
    function automatic logic [IDX_W-1:0] idx_step(input logic [IDX_W-1:0] cnt, input logic fwd);
        logic [IDX_W-1:0] nxt;
        nxt = cnt;
        if (fwd)
        begin
            if (cnt == IDX_LAST)
            begin
                nxt = IDX_FIRST;
            end
            else
            begin
                nxt = cnt + IDX_ONE;
            end
        end
        else
        begin
            if (cnt == IDX_FIRST)
            begin
                nxt = IDX_LAST;
            end
            else
            begin
                nxt = cnt - IDX_ONE;
            end
        end
        return nxt;
    endfunction

    assign healthy  = power_ok_i && light_ok_i && scale_clean_i;
    assign in_run   = (state_ff == lqeo_pkg::LQEO_RUN);
    assign step_ok  = move_step_i && in_run;
    assign step_fwd = is_fwd(move_dir_i);

    assign stp.step = step_ok;
    assign stp.dir  = step_fwd;

    lqeo_phase_gen u_phase
    (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .stp        (stp)
    );

    // A fault latches until the head is reset, so a brief dropout is not missed.
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            state_ff <= lqeo_pkg::LQEO_RUN;
        end
        else
        begin
            case (state_ff)
                lqeo_pkg::LQEO_RUN:
                begin
                    if (!healthy)
                    begin
                        state_ff <= lqeo_pkg::LQEO_FAULT;
                    end
                end
                lqeo_pkg::LQEO_FAULT:
                begin
                    state_ff <= lqeo_pkg::LQEO_FAULT;
                end
                default:
                begin
                    state_ff <= lqeo_pkg::LQEO_FAULT;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            fault_ff <= 1'h0;
        end
        else
        begin
            fault_ff <= !healthy || !in_run;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            chan_a_ff <= 1'h0;
            chan_b_ff <= 1'h0;
        end
        else
        begin
            chan_a_ff <= chan_a_of(stp.phase);
            chan_b_ff <= chan_b_of(stp.phase);
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            idx_cnt_ff <= IDX_FIRST;
        end
        else if (step_ok)
        begin
            idx_cnt_ff <= idx_step(idx_cnt_ff, step_fwd);
        end
    end

    assign nxt_at_index = (idx_cnt_ff == IDX_FIRST);

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            index_ff <= 1'h0;
        end
        else
        begin
            index_ff <= nxt_at_index;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            pos_ff <= '0;
        end
        else if (step_ok)
        begin
            if (step_fwd)
            begin
                pos_ff <= pos_ff + POS_ONE;
            end
            else
            begin
                pos_ff <= pos_ff - POS_ONE;
            end
        end
    end

    // The outputs come straight from flip-flops, fault_n_o through one inverter, so the pins never glitch.

    assign chan_a_o   = chan_a_ff;
    assign chan_b_o   = chan_b_ff;
    assign index_o    = index_ff;
    assign fault_o    = fault_ff;
    assign fault_n_o  = ~fault_ff;
    assign position_o = pos_ff;
endmodule // lqeo_encoder_out

// ==== design/lqeo_pkg.sv ====
package lqeo_pkg;
    // Grating period and interpolation in nanometres.
    localparam int unsigned GRATING_PERIOD_NM = 40000;
    localparam int unsigned RES_MIN_NM        = 500;
    localparam int unsigned RES_MAX_NM        = 10000;
    localparam int unsigned RES_DEFAULT_NM    = 1000;
    // Index spacing in nanometres (50 mm).
    localparam int unsigned INDEX_PITCH_NM    = 50000000;
    // Counts per quadrature cycle with 4x decoding.
    localparam int unsigned QUAD_STATES       = 4;
    // Maximum travel speed in mm/s.
    localparam int unsigned MAX_SPEED_MM_S    = 16000;
    localparam int unsigned CLK_MHZ           = 125;
    localparam int unsigned POS_W             = 32;
    localparam logic [1:0]  PHASE_RESET       = 2'h0;
    localparam logic        DIR_FWD           = 1'h1;

    typedef enum logic [1:0] {
        LQEO_RUN,
        LQEO_FAULT
    } lqeo_state_t;
endpackage

// ==== design/lqeo_step_if.sv ====
`timescale 1ns/100ps
interface lqeo_step_if;
    logic       step;
    logic       dir;
    logic [1:0] phase;

    modport gen
    (
        output phase,
        input  step,
        input  dir
    );
    modport ctl
    (
        input  phase,
        output step,
        output dir
    );
endinterface

// ==== design/lqeo_phase_gen.sv ====
`timescale 1ns/100ps
module lqeo_phase_gen
(
    input  wire logic   core_clk_i,
    input  wire logic   reset_i,
    lqeo_step_if.gen    stp
);
    logic [1:0] phase_ff;

    // Each step advances or retreats the quadrature state by one.
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            phase_ff <= lqeo_pkg::PHASE_RESET;
        else if (stp.step)
            phase_ff <= stp.dir ? phase_ff + 2'h1 : phase_ff - 2'h1;
    end

    assign stp.phase = phase_ff;
endmodule // lqeo_phase_gen

// ==== tb/lqeo_encoder_out_asserts.sv ====
`timescale 1ns/100ps
module lqeo_encoder_out_asserts
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic move_step_i,
    input wire logic power_ok_i,
    input wire logic light_ok_i,
    input wire logic scale_clean_i,
    input wire logic chan_a_o,
    input wire logic chan_b_o,
    input wire logic fault_o,
    input wire logic fault_n_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    wire healthy = power_ok_i & light_ok_i & scale_clean_i;
    sequence s_one_edge; $changed(chan_a_o) != $changed(chan_b_o); endsequence
    property p_step; move_step_i && !fault_o && healthy |-> ##2 s_one_edge; endproperty
    property p_quad; !($changed(chan_a_o) && $changed(chan_b_o)); endproperty
    property p_fault; !healthy |=> fault_o; endproperty
    property p_latch; fault_o |=> fault_o && !fault_n_o; endproperty
    property p_inv; fault_n_o != fault_o; endproperty
    a_step: assert property (p_step) else $error("step gave no single edge");
    a_quad: assert property (p_quad) else $error("A and B moved together");
    a_fault: assert property (p_fault) else $error("fault not raised");
    a_latch: assert property (p_latch) else $error("fault dropped");
    a_inv: assert property (p_inv) else $error("fault pair not inverse");
endmodule // lqeo_encoder_out_asserts
bind lqeo_encoder_out lqeo_encoder_out_asserts i_chk(.core_clk_i(core_clk_i), .reset_i(reset_i),
    .move_step_i(move_step_i), .power_ok_i(power_ok_i), .light_ok_i(light_ok_i), .scale_clean_i(scale_clean_i),
    .chan_a_o(chan_a_o), .chan_b_o(chan_b_o), .fault_o(fault_o), .fault_n_o(fault_n_o));

// ==== tb/lqeo_decoder_model.sv ====
`timescale 1ns/100ps
module lqeo_decoder_model
(
    input  wire logic   clk_i,
    input  wire logic   reset_i,
    input  wire logic   chan_a_i,
    input  wire logic   chan_b_i,
    input  wire logic   index_i,
    input  wire logic   fault_i,
    output logic [31:0] count_o,
    output logic        homed_o,
    output logic        stop_o
);
    logic [1:0] prev_ff;
    wire  [1:0] cur  = {chan_a_i, chan_a_i ^ chan_b_i};
    wire  [1:0] diff = cur - prev_ff;
    always_ff @(posedge clk_i)
    begin
        if (reset_i) homed_o <= 1'h0;
        else if (index_i) homed_o <= 1'h1;
    end
    always_ff @(posedge clk_i)
    begin
        stop_o <= reset_i ? 1'h0 : fault_i;
    end
    always_ff @(posedge clk_i)
    begin
        prev_ff <= reset_i ? 2'h0 : cur;
        if (reset_i) count_o <= 32'h0;
        else if (diff == 2'h1) count_o <= count_o + 32'h1;
        else if (diff == 2'h3) count_o <= count_o - 32'h1;
    end
endmodule // lqeo_decoder_model

// ==== tb/tb.sv ====
`timescale 1ns/100ps
module tb;
    logic core_clk_i = 0, reset_i = 1, stp = 0, dir = 1, pwr = 1, lit = 1, cln = 1;
    logic a, b, idx, flt, flt_n, home, stop;
    logic [31:0] pos, cnt;
    logic [1:0] quad [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    int mismatches = 0, num_checks = 0, cyc = 0;
    always #4 core_clk_i = ~core_clk_i;
    lqeo_encoder_out #(.RES_NM(10000000)) i_lqeo_encoder_out(.core_clk_i(core_clk_i), .reset_i(reset_i),
        .move_step_i(stp), .move_dir_i(dir), .power_ok_i(pwr), .light_ok_i(lit), .scale_clean_i(cln),
        .chan_a_o(a), .chan_b_o(b), .index_o(idx), .fault_o(flt), .fault_n_o(flt_n), .position_o(pos));
    lqeo_decoder_model i_lqeo_decoder_model(.clk_i(core_clk_i), .reset_i(reset_i), .chan_a_i(a),
        .chan_b_i(b), .index_i(idx), .fault_i(flt), .count_o(cnt), .homed_o(home), .stop_o(stop));
    task complete_run;
        if (mismatches == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task do_reset;
        @(posedge core_clk_i);
        reset_i <= 1;
        repeat (16) @(posedge core_clk_i);
        reset_i <= 0;
    endtask
    task move(input logic d);
        @(posedge core_clk_i);
        stp <= 1;
        dir <= d;
        @(posedge core_clk_i);
        stp <= 0;
        repeat (3) @(posedge core_clk_i);
        #1;
    endtask
    task t_forward;
        for (int i = 1; i <= 12; i++)
        begin
            move(1);
            chk(home, 1);
            chk(pos, i);
            chk(cnt, i);
            chk({a, b}, quad[i % 4]);
            chk(idx, (i % 5) == 0);
        end
    endtask
    task t_reverse;
        for (int i = 11; i >= 0; i--)
        begin
            move(0);
            chk(pos, i);
            chk(cnt, i);
            chk({a, b}, quad[i % 4]);
            chk(idx, (i % 5) == 0);
        end
    endtask
    task t_fault;
        for (int k = 0; k < 3; k++)
        begin
            do_reset;
            @(posedge core_clk_i);
            {pwr, lit, cln} <= ~(3'h4 >> k);
            @(posedge core_clk_i);
            {pwr, lit, cln} <= 3'h7;
            repeat (2) @(posedge core_clk_i);
            chk({flt, flt_n}, 2'h2);
            chk(stop, 1);
            move(1);
            move(1);
            chk(cnt, 0);
        end
    endtask
    always @(posedge core_clk_i)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            mismatches++;
            complete_run;
        end
    end
    initial
    begin
        do_reset;
        t_forward;
        t_reverse;
        t_fault;
        complete_run;
    end
endmodule // tb
